// *** rtl/tx_timing_ctrl.sv ***
// Transmit timing source, pin direction and framer loopback control for one T1 channel.
// Assumes clock and status pins are asynchronous to hclk; data words arrive on hclk.
//
// Contract
// - Source field 00 or 11 times the transmitter from the recovered line clock.
// - Source field 01 times the transmitter from the external serial clock pin.
// - Source field 10 times the transmitter from the internal PLL clock.
// - At base rate the serial clock is driven in loop and internal timing.
// - High-speed back plane: serial clock and both sync pins are inputs only.
// - Source field resets to 01, external timing.
// - Force bit set sends the no-signal pattern to the line.
// - Rail bit: 0 dual rail, 1 single rail; LIU must match.
// - Loopback field 00, the reset value, means no loopback.
// - Loopback 01 returns transmit PCM to receive PCM, sends all ones.
// - Loopback 10 returns received line data to the line, bypassing framing.
// - Loopback 11 re-frames received payload on transmit timing toward the line.
// - With protection on, lost line recovery in loop timing falls back to internal.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tx_timing_ctrl
  import tx_timing_pkg::*;
#(
  parameter int DEPTH = BUFFER_DEPTH
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic      [31:0]           hrdata,
  input  wire logic                  recovered_line_clock,
  input  wire logic                  line_clock_recovered,
  input  wire logic                  internal_pll_clock,
  input  wire logic                  high_speed_backplane,
  input  wire frame_pins_s           pins_in,
  output frame_pins_s                pins_out,
  output frame_pins_s                pins_oe,
  input  wire logic                  tx_pcm_valid,
  output logic                       tx_pcm_ready,
  input  wire logic [WORD_W-1:0]     tx_pcm_data,
  input  wire line_word_s            rx_line,
  output line_word_s                 rx_pcm,
  output logic                       line_tx_valid,
  input  wire logic                  line_tx_ready,
  output logic      [WORD_W-1:0]     line_tx_data,
  output logic                       single_rail
);

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  logic [7:0]        timing_select;
  logic [7:0]        line_side_control;
  logic              wr_pending;
  logic [ADDR_W-1:0] wr_addr;
  logic              addr_phase;

  // ----------------------------------------------------------------
  // Synchronisers and timing
  // ----------------------------------------------------------------
  logic [4:0]        sync_a;
  logic [4:0]        sync_b;
  logic              src_level;
  logic              src_prev;
  logic              tx_tick;
  timing_e           timing;
  timing_e           next_timing;
  logic              fallback;
  logic              drive_clock;
  logic              drive_syncs;
  logic [7:0]        bit_count;
  logic [4:0]        frame_count;
  logic              frame_pulse;
  logic              multi_pulse;

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  logic [1:0]        loopback;
  logic              force_no_signal;
  logic              payload_valid;
  logic [WORD_W-1:0] payload_word;
  logic              buf_in_valid;
  logic              buf_in_ready;
  logic [WORD_W-1:0] buf_in_data;

  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] addr,
                                          input logic [7:0] sel,
                                          input logic [7:0] ctl,
                                          input logic [7:0] stat);
    case (addr)
      TIMING_SELECT_ADDR: read_reg = sel;
      LINE_CONTROL_ADDR:  read_reg = ctl;
      TIMING_STATUS_ADDR: read_reg = stat;
      default:            read_reg = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr    <= '0;
    end else if (hready) begin
      wr_pending <= addr_phase && hwrite;
      wr_addr    <= haddr[ADDR_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {24'h000000, read_reg(haddr[ADDR_W-1:0], timing_select, line_side_control,
                 {3'h0, fallback, sync_b[1], drive_clock, timing[1:0]})};
    end
  end

  // Whole byte kept, so reserved bits read back unchanged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timing_select     <= TIMING_SELECT_RESET;
      line_side_control <= LINE_CONTROL_RESET;
    end else if (wr_pending) begin
      if (wr_addr == TIMING_SELECT_ADDR) begin
        timing_select <= hwdata[7:0];
      end
      if (wr_addr == LINE_CONTROL_ADDR) begin
        line_side_control <= hwdata[7:0];
      end
    end
  end

  assign loopback        = line_side_control[LOOPBACK_LSB +: 2];
  assign force_no_signal = line_side_control[FORCE_NO_SIGNAL_BIT];
  // Software must set the LIU to single rail first
  assign single_rail     = line_side_control[RAIL_MODE_BIT];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {high_speed_backplane, pins_in.serial_clock, internal_pll_clock,
                 line_clock_recovered, recovered_line_clock};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // Timing source selection
  // ----------------------------------------------------------------
  always_comb begin
    fallback = 1'b0;
    case (timing_select[CLK_SRC_LSB +: 2])
      SRC_EXTERNAL: next_timing = TIMING_EXTERNAL;
      SRC_INTERNAL: next_timing = TIMING_INTERNAL;
      default: begin
        next_timing = TIMING_LOOP;
        if (timing_select[CLK_LOSS_EN_BIT] && !sync_b[1]) begin
          next_timing = TIMING_INTERNAL;
          fallback    = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timing <= TIMING_EXTERNAL;
    end else begin
      timing <= next_timing;
    end
  end

  always_comb begin
    case (timing)
      TIMING_LOOP:     src_level = sync_b[0];
      TIMING_INTERNAL: src_level = sync_b[2];
      default:         src_level = sync_b[3];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign tx_tick = src_level && !src_prev;

  // ----------------------------------------------------------------
  // Pin directions
  // ----------------------------------------------------------------
  assign drive_clock = !sync_b[4] && (timing != TIMING_EXTERNAL);
  assign drive_syncs = !sync_b[4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_oe  <= '0;
      pins_out <= '0;
    end else begin
      pins_oe.serial_clock     <= drive_clock;
      pins_oe.frame_sync       <= drive_syncs;
      pins_oe.multiframe_sync  <= drive_syncs;
      pins_out.serial_clock    <= src_level;
      pins_out.frame_sync      <= frame_pulse;
      pins_out.multiframe_sync <= multi_pulse;
    end
  end

  // Frame counters run on transmit timing ticks only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_count   <= '0;
      frame_count <= '0;
    end else if (tx_tick) begin
      if (bit_count == FRAME_TICKS - 8'h01) begin
        bit_count <= '0;
        if (frame_count == FRAMES_PER_MULTI - 5'h01) begin
          frame_count <= '0;
        end else begin
          frame_count <= frame_count + 5'h01;
        end
      end else begin
        bit_count <= bit_count + 8'h01;
      end
    end
  end

  assign frame_pulse = (bit_count == 8'h00);
  assign multi_pulse = frame_pulse && (frame_count == 5'h00);

  // ----------------------------------------------------------------
  // Receive PCM output
  // ----------------------------------------------------------------
  assign tx_pcm_ready = (loopback == LB_NONE) ? (tx_tick && buf_in_ready) : 1'b1;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pcm <= '0;
    end else if (loopback == LB_LOCAL) begin
      rx_pcm.valid <= tx_pcm_valid;
      rx_pcm.data  <= tx_pcm_data;
    end else begin
      rx_pcm <= rx_line;
    end
  end

  // Received payload held until the next transmit tick re-frames it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      payload_valid <= 1'b0;
      payload_word  <= '0;
    end else if (loopback != LB_PAYLOAD) begin
      payload_valid <= 1'b0;
    end else if (rx_line.valid) begin
      payload_valid <= 1'b1;
      payload_word  <= rx_line.data;
    end else if (tx_tick && buf_in_ready) begin
      payload_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Line transmit selection
  // ----------------------------------------------------------------
  always_comb begin
    buf_in_valid = 1'b0;
    buf_in_data  = tx_pcm_data;
    case (loopback)
      LB_LOCAL: begin
        buf_in_valid = tx_tick;
        buf_in_data  = ALL_ONES_WORD;
      end
      LB_REMOTE: begin
        buf_in_valid = rx_line.valid;
        buf_in_data  = rx_line.data;
      end
      LB_PAYLOAD: begin
        buf_in_valid = tx_tick && payload_valid;
        buf_in_data  = payload_word;
      end
      default: begin
        buf_in_valid = tx_tick && tx_pcm_valid;
      end
    endcase
    if (force_no_signal) begin
      buf_in_valid = tx_tick;
      buf_in_data  = NO_SIGNAL_WORD;
    end
  end

  // Two entries let a one-tick stall by the LIU lose nothing
  word_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_line_buffer (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (line_tx_valid),
    .out_ready (line_tx_ready),
    .out_data  (line_tx_data)
  );

endmodule
`default_nettype wire

// *** common/tx_timing_pkg.sv ***
// Constants and carrier types for the transmit timing and loopback control block.
// Assumes a single 32-bit AHB-Lite register bus on hclk.
package tx_timing_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] TIMING_SELECT_INDEX  = 16'h0100;
  localparam logic [15:0] LINE_CONTROL_INDEX   = 16'h0101;
  localparam logic [15:0] TIMING_STATUS_INDEX  = 16'h0102;
  localparam int          ADDR_W               = 18;
  localparam logic [17:0] TIMING_SELECT_ADDR   = {TIMING_SELECT_INDEX, 2'b00};
  localparam logic [17:0] LINE_CONTROL_ADDR    = {LINE_CONTROL_INDEX, 2'b00};
  localparam logic [17:0] TIMING_STATUS_ADDR   = {TIMING_STATUS_INDEX, 2'b00};

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CLK_SRC_LSB          = 0;
  localparam int          CLK_LOSS_EN_BIT      = 4;
  localparam int          LOOPBACK_LSB         = 4;
  localparam int          RAIL_MODE_BIT        = 6;
  localparam int          FORCE_NO_SIGNAL_BIT  = 7;
  localparam logic [7:0]  TIMING_SELECT_RESET  = 8'h11;
  localparam logic [7:0]  LINE_CONTROL_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0]  SRC_LOOP             = 2'h0;
  localparam logic [1:0]  SRC_EXTERNAL         = 2'h1;
  localparam logic [1:0]  SRC_INTERNAL         = 2'h2;
  localparam logic [1:0]  LB_NONE              = 2'h0;
  localparam logic [1:0]  LB_LOCAL             = 2'h1;
  localparam logic [1:0]  LB_REMOTE            = 2'h2;
  localparam logic [1:0]  LB_PAYLOAD           = 2'h3;

  // ----------------------------------------------------------------
  // Line words and framing counts
  // ----------------------------------------------------------------
  localparam int          WORD_W               = 8;
  localparam logic [7:0]  ALL_ONES_WORD        = 8'hff;
  localparam logic [7:0]  NO_SIGNAL_WORD       = 8'h00;
  localparam logic [7:0]  FRAME_TICKS          = 8'hc1;
  localparam logic [4:0]  FRAMES_PER_MULTI     = 5'h18;
  localparam int          BUFFER_DEPTH         = 2;

  typedef enum logic [1:0] {
    TIMING_LOOP,
    TIMING_EXTERNAL,
    TIMING_INTERNAL
  } timing_e;

  // Three back-plane timing pins travel together
  typedef struct packed {
    logic serial_clock;
    logic frame_sync;
    logic multiframe_sync;
  } frame_pins_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } line_word_s;

endpackage

// *** rtl/word_buffer.sv ***
// Small valid/ready FIFO in the line transmit path.
// Assumes both sides on the same clock; depth is a power of two.
`timescale 1ns/10ps
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] slots [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != (PTR_W+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (push) begin
      slots[wr_ptr] <= in_data;
    end
  end

  // Data out is registered: takes in_data when empty or its last word pops, else the next slot on a pop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_data <= '0;
    end else if (push && (!out_valid || (pop && fill == (PTR_W+1)'(1)))) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data <= slots[rd_ptr + PTR_W'(1)];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      if (push && !pop) begin
        fill <= fill + (PTR_W+1)'(1);
      end else if (pop && !push) begin
        fill <= fill - (PTR_W+1)'(1);
      end
    end
  end

endmodule
`default_nettype wire

// *** sim/tx_timing_ctrl_sva.sv ***
// Checker for the transmit timing and loopback control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tx_timing_ctrl_sva
  import tx_timing_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        high_speed_backplane,
  input wire frame_pins_s pins_oe,
  input wire logic        tx_pcm_valid,
  input wire logic [7:0]  tx_pcm_data,
  input wire line_word_s  rx_line,
  input wire line_word_s  rx_pcm,
  input wire logic        line_tx_valid,
  input wire logic        line_tx_ready,
  input wire logic [7:0]  line_tx_data,
  input wire logic        single_rail
);
  // --------------------------------
  // Shadow registers
  // --------------------------------
  logic        w_q;
  logic [17:0] a_q;
  logic [7:0]  sel_q;
  logic [7:0]  ctl_q;
  logic [3:0]  age;
  logic [2:0]  hsk;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_q   <= 1'b0;
      a_q   <= '0;
      sel_q <= TIMING_SELECT_RESET;
      ctl_q <= LINE_CONTROL_RESET;
    end else if (hready) begin
      w_q <= hsel && htrans[1] && hwrite;
      a_q <= haddr[17:0];
      if (w_q && a_q == TIMING_SELECT_ADDR) sel_q <= hwdata[7:0];
      if (w_q && a_q == LINE_CONTROL_ADDR) ctl_q <= hwdata[7:0];
    end
  end
  // Handshake count lets words queued before a mode change drain first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      age <= '0;
      hsk <= '0;
    end else if (w_q && hready) begin
      age <= '0;
      hsk <= '0;
    end else begin
      if (age != 4'hf) age <= age + 4'h1;
      if (line_tx_valid && line_tx_ready && hsk != 3'h7) hsk <= hsk + 3'h1;
    end
  end
  // --------------------------------
  // Assertions
  // --------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [31:0] a);
    hsel && htrans[1] && !hwrite && hready && haddr == a;
  endsequence
  sequence settled;
    !high_speed_backplane [*4] ##0 age == 4'hf;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  a_read_sel: assert property (rd_at(32'h400) |=> hrdata == {24'h0, $past(sel_q)})
    else $error("select read wrong");
  a_read_ctl: assert property (rd_at(32'h404) |=> hrdata == {24'h0, $past(ctl_q)})
    else $error("control read wrong");
  a_unmapped_zero: assert property (rd_at(32'h40c) |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_backplane_inputs: assert property (high_speed_backplane [*4] |=> pins_oe == 3'b000)
    else $error("pin driven at high speed");
  a_sync_driven: assert property (!high_speed_backplane [*4] |=> pins_oe[1:0] == 2'b11)
    else $error("sync pins not driven");
  a_clock_dir: assert property (settled |-> pins_oe.serial_clock == (sel_q[1:0] != SRC_EXTERNAL))
    else $error("clock direction wrong");
  a_rail_follows: assert property (age == 4'hf |-> single_rail == ctl_q[RAIL_MODE_BIT])
    else $error("rail mode not applied");
  a_local_return: assert property (ctl_q[5:4] == LB_LOCAL && age == 4'hf && tx_pcm_valid
    |=> rx_pcm.valid && rx_pcm.data == $past(tx_pcm_data)) else $error("local loop word lost");
  a_normal_receive: assert property (ctl_q[5:4] == LB_NONE && age == 4'hf && rx_line.valid
    |=> rx_pcm.valid && rx_pcm.data == $past(rx_line.data)) else $error("received word lost");
  a_local_ones: assert property (ctl_q[5:4] == LB_LOCAL && !ctl_q[7] && hsk == 3'h7 && line_tx_valid
    |-> line_tx_data == ALL_ONES_WORD) else $error("local loop not sending ones");
  a_force_zero: assert property (ctl_q[7] && hsk == 3'h7 && line_tx_valid |-> line_tx_data == NO_SIGNAL_WORD)
    else $error("no signal pattern missing");
endmodule
bind tx_timing_ctrl tx_timing_ctrl_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .high_speed_backplane, .pins_oe, .tx_pcm_valid, .tx_pcm_data, .rx_line, .rx_pcm,
  .line_tx_valid, .line_tx_ready, .line_tx_data, .single_rail);
`default_nettype wire

// *** sim/liu_model.sv ***
// Line interface unit model: takes line words, sends received words.
// Assumes the bench steers stall and clock recovery.
`timescale 1ns/10ps
`default_nettype none
module liu_model
  import tx_timing_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       stall,
  input  wire logic       recovery_ok,
  input  wire logic       line_tx_valid,
  input  wire logic [7:0] line_tx_data,
  output logic            line_tx_ready,
  output line_word_s      rx_line,
  output logic            recovered_line_clock,
  output logic            line_clock_recovered
);
  logic [7:0] got[$];
  logic [1:0] div;
  assign line_tx_ready = !stall;
  assign line_clock_recovered = recovery_ok;
  initial rx_line = '{valid: 1'b0, data: 8'h00};
  // Recovered clock stops when recovery is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div                  <= '0;
      recovered_line_clock <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3 && recovery_ok) recovered_line_clock <= !recovered_line_clock;
    end
  end
  always @(posedge hclk) if (line_tx_valid && line_tx_ready) got.push_back(line_tx_data);
  // Idle data inverted so a stale word is never mistaken for a new one
  task automatic send_rx(input logic [7:0] d);
    @(posedge hclk);
    rx_line <= '{valid: 1'b1, data: d};
    @(posedge hclk);
    rx_line <= '{valid: 1'b0, data: ~d};
  endtask
endmodule
`default_nettype wire

// *** sim/t1_tx_timing_and_loopback_ctrl_bench.sv ***
// Self-checking bench for the transmit timing and loopback control block.
// Assumes the line model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module t1_tx_timing_and_loopback_ctrl_bench;
  import tx_timing_pkg::*;
  localparam logic [31:0] SEL = 32'(TIMING_SELECT_ADDR);
  localparam logic [31:0] CTL = 32'(LINE_CONTROL_ADDR);
  localparam logic [31:0] STAT = 32'(TIMING_STATUS_ADDR);
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_pcm_valid, tx_pcm_ready, single_rail;
  logic        high_speed_backplane, internal_pll_clock, stall, recovery_ok, line_tx_valid, line_tx_ready;
  logic        recovered_line_clock, line_clock_recovered, prev;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [7:0]  tx_pcm_data, line_tx_data;
  logic [3:0]  cnt;
  frame_pins_s pins_in, pins_out, pins_oe;
  line_word_s  rx_line, rx_pcm;
  int          n_mismatch, compares, edges;
  tx_timing_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .recovered_line_clock, .line_clock_recovered, .internal_pll_clock,
    .high_speed_backplane, .pins_in, .pins_out, .pins_oe, .tx_pcm_valid, .tx_pcm_ready, .tx_pcm_data, .rx_line,
    .rx_pcm, .line_tx_valid, .line_tx_ready, .line_tx_data, .single_rail);
  liu_model liu (.hclk, .hresetn, .stall, .recovery_ok, .line_tx_valid, .line_tx_data, .line_tx_ready, .rx_line,
    .recovered_line_clock, .line_clock_recovered);
  initial begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cnt <= cnt + 4'h1;
    internal_pll_clock <= cnt[1];
    pins_in.serial_clock <= cnt[3];
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic pcm_send(input logic [7:0] d);
    @(posedge hclk);
    tx_pcm_valid <= 1'b1; tx_pcm_data <= d;
    do @(posedge hclk); while (!tx_pcm_ready);
    tx_pcm_valid <= 1'b0;
  endtask
  task automatic line_last(input string what, input logic [7:0] exp, input logic rx);
    liu.got.delete();
    if (rx) liu.send_rx(exp);
    repeat (60) @(posedge hclk);
    check(what, liu.got.size() > 0 ? liu.got[$] : 8'hxx, exp);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_registers();
    rdchk("timing select reset", SEL, 32'h11);
    rdchk("line control reset", CTL, 32'h00);
    bus(1'b1, 32'h40c, 32'hff);
    rdchk("unmapped", 32'h40c, 32'h0);
    bus(1'b1, SEL, 32'hed);
    rdchk("reserved bits", SEL, 32'hed);
    bus(1'b1, CTL, 32'h0f);
    rdchk("reserved line bits", CTL, 32'h0f);
  endtask
  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, SEL, 32'h10 | s);
      rdchk("timing source", STAT, {29'h1, s != 1, s == 3 ? 2'h0 : 2'(s)});
      check("clock direction", pins_oe.serial_clock, s != 1);
      edges = 0;
      repeat (48) begin
        prev = pins_out.serial_clock;
        @(posedge hclk);
        edges += int'(pins_out.serial_clock && !prev);
      end
      check("clock edges", edges, s == 2 ? 12 : s == 1 ? 3 : 6);
    end
  endtask
  task automatic t_fallback();
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, SEL, k == 0 ? 32'h00 : 32'h10);
      recovery_ok <= (k == 2);
      repeat (10) @(posedge hclk);
      bus(1'b0, STAT, 32'h0);
      check("fallback", {rd[4], rd[1:0]}, k == 1 ? 3'b110 : 3'b000);
    end
  endtask
  task automatic t_backplane();
    high_speed_backplane <= 1'b1;
    repeat (6) @(posedge hclk);
    check("high speed pins", pins_oe, 3'b000);
    high_speed_backplane <= 1'b0;
    repeat (6) @(posedge hclk);
    check("base rate sync", pins_oe.frame_sync, 1'b1);
  endtask
  task automatic t_paths();
    bus(1'b1, SEL, 32'h12);
    bus(1'b1, CTL, 32'h00);
    liu.got.delete();
    stall <= 1'b1;
    pcm_send(8'ha5);
    pcm_send(8'h3c);
    @(posedge hclk);
    tx_pcm_valid <= 1'b1; tx_pcm_data <= 8'h69;
    repeat (30) @(posedge hclk);
    check("full buffer refuses", tx_pcm_ready, 1'b0);
    stall <= 1'b0;
    do @(posedge hclk); while (!tx_pcm_ready);
    tx_pcm_valid <= 1'b0;
    repeat (30) @(posedge hclk);
    check("order", {liu.got[0], liu.got[1], liu.got[2]}, 24'ha53c69);
    liu.send_rx(8'h96);
    @(negedge hclk);
    check("receive path", rx_pcm, 9'h196);
    bus(1'b1, CTL, 32'h10);
    repeat (16) @(posedge hclk);
    pcm_send(8'h5a);
    @(negedge hclk);
    check("local return", rx_pcm, 9'h15a);
    line_last("local ones", 8'hff, 1'b0);
    bus(1'b1, CTL, 32'h20);
    line_last("remote loop", 8'hc3, 1'b1);
    bus(1'b1, CTL, 32'h30);
    line_last("payload loop", 8'h81, 1'b1);
    bus(1'b1, CTL, 32'hb0);
    line_last("no signal", 8'h00, 1'b0);
    bus(1'b1, CTL, 32'h40);
    repeat (20) @(posedge hclk);
    check("single rail", single_rail, 1'b1);
    bus(1'b1, CTL, 32'h00);
    repeat (20) @(posedge hclk);
    check("dual rail", single_rail, 1'b0);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    summarize();
  end
  initial begin
    hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0; cnt = 0;
    tx_pcm_valid = 0; tx_pcm_data = 0; high_speed_backplane = 0; internal_pll_clock = 0;
    stall = 0; recovery_ok = 1; pins_in = '0; n_mismatch = 0; compares = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_registers();
    t_sources();
    t_fallback();
    t_backplane();
    t_paths();
    summarize();
  end
endmodule
`default_nettype wire
